//--- core/epc_counter.sv
// Event pulse counter with AHB-Lite register slave
//
// Overview of operation
// [R1] 16-bit up counter, readable and writable, steps on each selected clock edge.
// [R2] Sources: system clock /4, /6, /32, subclock /4, or external clock.
// [R3] 8-bit clock control register picks 16/8-bit mode and input clocks.
// [R4] 8-bit control/status holds clear select, overflow, compare flags, irq enable.
// [R5] External source takes its pulses from the event input pin.
// [R6] Upper select field 000, 001 or 010 makes one 16-bit counter.
// [R7] Lower select field 000, 001 or 010 counts external event edges.
// [R8] Overflow flag bit 7 sets on counter overflow, else reads 0.
// [R9] Compare-match flag bit 6 sets on compare match, else reads 0.
// [R10] Overflow irq enable bit 5 permits overflow requests when 1.
// [R11] Clear enable bit 4 makes compare match clear the counter.
// [R12] Upper overflow raises request flag, forwarded only while its gate is set.
// [R13] Software counts 1024 rising edges, seeing completion by overflow interrupt.
// [R14] Software then stops external clock input so counting ends.
// [R15] Handler sets completion flag in memory and disables counter interrupts.
// [R16] Edge select bit 3: rising edges when 1, falling when 0.
// [R17] Port mode bit 7: general port when 0, event input when 1.
// [R18] Increment from all ones wraps to zero while setting overflow flag.
// [R19] Flags stay set until written 0; writing 1 never sets them.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module epc_counter (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic event_input_pin,
   input wire logic subclk_in,
   output logic irq
);
   import epc_pkg::*;

   typedef struct packed {
      logic dp_wr;
      logic [31:0] dp_addr;
      logic [31:0] rdata;
      logic [2:0] upper_sel;
      logic [2:0] lower_sel;
      logic overflow_flag;
      logic compare_match_flag;
      logic overflow_irq_enable;
      logic compare_clear_enable;
      logic [15:0] count;
      logic [15:0] compare;
      logic pin_fn;
      logic edge_rise;
      logic [1:0] irq_gate;
      logic [1:0] irq_req;
      logic irq;
   } epc_state_t;

   epc_state_t s_r;
   epc_state_t s_nxt;

   logic ev_edge;
   logic sub_edge;
   logic d4;
   logic d6;
   logic d32;
   logic s4;
   logic ext_tick;
   logic lo_tick;
   logic up_tick;
   logic mode16;

   ////////////////////////////////////////////////////////////////////////////
   // Clock sources

   epc_edge u_ev_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .din(event_input_pin),
      .rise_sel(s_r.edge_rise),
      .pulse(ev_edge)
   );

   epc_edge u_sub_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .din(subclk_in),
      .rise_sel(1'b1),
      .pulse(sub_edge)
   );

   epc_divider #(.DIV(EPC_DIV_SYS4)) u_div4 (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(1'b1),
      .tick(d4)
   );

   epc_divider #(.DIV(EPC_DIV_SYS6)) u_div6 (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(1'b1),
      .tick(d6)
   );

   epc_divider #(.DIV(EPC_DIV_SYS32)) u_div32 (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(1'b1),
      .tick(d32)
   );

   epc_divider #(.DIV(EPC_DIV_SUB4)) u_sub4 (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(sub_edge),
      .tick(s4)
   );

   // Pin serves as event input only in its event function
   assign ext_tick = ev_edge & s_r.pin_fn; // [R5] [R16] [R17]

   // Sources are arguments so the assigns wake on every tick
   function automatic logic pick(input logic [2:0] f, input logic [4:0] src);
      case (f)
         3'h0, 3'h1, EPC_SEL_EXT_MAX: pick = src[0]; // [R7]
         EPC_SEL_SYS32: pick = src[1]; // [R2]
         EPC_SEL_SYS6: pick = src[2];
         EPC_SEL_SYS4: pick = src[3];
         EPC_SEL_SUB4: pick = src[4];
         default: pick = 1'b0;
      endcase
   endfunction

   assign mode16 = (s_r.upper_sel <= EPC_SEL_EXT_MAX); // [R6]
   assign lo_tick = pick(s_r.lower_sel, {s4, d4, d6, d32, ext_tick}); // [R3]
   assign up_tick = pick(s_r.upper_sel, {s4, d4, d6, d32, ext_tick});

   ////////////////////////////////////////////////////////////////////////////
   // Register read mux

   function automatic logic [31:0] rd_word(input logic [31:0] a, input epc_state_t s);
      rd_word = 32'h0000_0000;
      case (a)
         EPC_ADDR_CLK_CTRL:
            rd_word[7:0] = {1'b0, s.upper_sel, 1'b0, s.lower_sel};
         EPC_ADDR_CTRL_STAT:
            rd_word[7:0] = {s.overflow_flag, s.compare_match_flag,
               s.overflow_irq_enable, s.compare_clear_enable, 4'h0}; // [R4]
         EPC_ADDR_COUNT: rd_word[15:0] = s.count; // [R1]
         EPC_ADDR_COMPARE: rd_word[15:0] = s.compare;
         EPC_ADDR_PORT_MODE: rd_word[EPC_PIN_FN_BIT] = s.pin_fn;
         EPC_ADDR_EDGE_SEL: rd_word[EPC_EDGE_BIT] = s.edge_rise;
         EPC_ADDR_IRQ_MASK: rd_word[1:0] = s.irq_gate;
         EPC_ADDR_IRQ_STAT: rd_word[1:0] = s.irq_req;
         default: rd_word = 32'h0000_0000;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      logic wr_cs;
      logic ovf_ev;
      logic cmf_ev;
      logic [15:0] cnt;
      wr_cs = 1'b0;
      ovf_ev = 1'b0;
      cmf_ev = 1'b0;
      cnt = s_r.count;
      s_nxt = s_r;

      // Address phase capture; read data staged for the data phase
      s_nxt.dp_wr = 1'b0;
      if (hsel && hready && htrans[1])
      begin
         s_nxt.dp_wr = hwrite;
         s_nxt.dp_addr = haddr;
         s_nxt.rdata = rd_word(haddr, s_r);
      end

      // Counting
      if (mode16)
      begin
         if (lo_tick)
         begin
            ovf_ev = (cnt == EPC_COUNT_MAX); // [R18]
            cnt = cnt + 16'h0001; // [R1] [R18]
            cmf_ev = (cnt == s_r.compare);
         end
      end
      else
      begin
         if (lo_tick)
         begin
            cnt[7:0] = cnt[7:0] + 8'h01;
         end
         if (up_tick)
         begin
            ovf_ev = (cnt[15:8] == EPC_BYTE_MAX); // [R12]
            cnt[15:8] = cnt[15:8] + 8'h01;
         end
         cmf_ev = (lo_tick | up_tick) && (cnt == s_r.compare);
      end
      if (cmf_ev && s_r.compare_clear_enable)
      begin
         cnt = 16'h0000; // [R11]
      end

      // Software write of the count wins over a tick in the same cycle
      if (s_r.dp_wr && s_r.dp_addr == EPC_ADDR_COUNT)
      begin
         cnt = hwdata[15:0]; // [R1]
         ovf_ev = 1'b0;
         cmf_ev = 1'b0;
      end
      s_nxt.count = cnt;

      // Register writes
      if (s_r.dp_wr)
      begin
         case (s_r.dp_addr)
            EPC_ADDR_CLK_CTRL:
            begin
               s_nxt.upper_sel = hwdata[EPC_UPPER_SEL_LSB +: 3]; // [R3]
               s_nxt.lower_sel = hwdata[EPC_LOWER_SEL_LSB +: 3];
            end
            EPC_ADDR_CTRL_STAT:
            begin
               wr_cs = 1'b1;
               s_nxt.overflow_irq_enable = hwdata[EPC_OVIE_BIT]; // [R10]
               s_nxt.compare_clear_enable = hwdata[EPC_CCLR_BIT]; // [R11]
            end
            EPC_ADDR_COMPARE: s_nxt.compare = hwdata[15:0];
            EPC_ADDR_PORT_MODE: s_nxt.pin_fn = hwdata[EPC_PIN_FN_BIT]; // [R17]
            EPC_ADDR_EDGE_SEL: s_nxt.edge_rise = hwdata[EPC_EDGE_BIT]; // [R16]
            EPC_ADDR_IRQ_MASK: s_nxt.irq_gate = hwdata[1:0]; // [R12]
            EPC_ADDR_IRQ_STAT: s_nxt.irq_req = s_r.irq_req & ~hwdata[1:0];
            default: s_nxt.irq_gate = s_r.irq_gate;
         endcase
      end

      // Flags: writing 0 clears, writing 1 keeps, event wins
      if (wr_cs && !hwdata[EPC_OVF_BIT])
      begin
         s_nxt.overflow_flag = 1'b0; // [R19]
      end
      if (wr_cs && !hwdata[EPC_CMF_BIT])
      begin
         s_nxt.compare_match_flag = 1'b0; // [R19]
      end
      if (ovf_ev)
      begin
         s_nxt.overflow_flag = 1'b1; // [R8] [R18]
      end
      if (cmf_ev)
      begin
         s_nxt.compare_match_flag = 1'b1; // [R9]
      end

      // Sticky requests; set wins over write-one-to-clear
      if (ovf_ev && s_r.overflow_irq_enable)
      begin
         s_nxt.irq_req[EPC_IRQ_OVF_BIT] = 1'b1; // [R10] [R12]
      end
      if (cmf_ev)
      begin
         s_nxt.irq_req[EPC_IRQ_CMF_BIT] = 1'b1;
      end
      s_nxt.irq = |(s_nxt.irq_req & s_nxt.irq_gate); // [R12]
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r.dp_wr <= 1'b0;
         s_r.dp_addr <= 32'h0000_0000;
         s_r.rdata <= 32'h0000_0000;
         s_r.upper_sel <= EPC_RST_SEL;
         s_r.lower_sel <= EPC_RST_SEL;
         s_r.overflow_flag <= 1'b0;
         s_r.compare_match_flag <= 1'b0;
         s_r.overflow_irq_enable <= 1'b0;
         s_r.compare_clear_enable <= 1'b0;
         s_r.count <= EPC_RST_COUNT;
         s_r.compare <= EPC_RST_COMPARE;
         s_r.pin_fn <= EPC_RST_PIN_FN;
         s_r.edge_rise <= EPC_RST_EDGE_RISE;
         s_r.irq_gate <= EPC_RST_IRQ;
         s_r.irq_req <= EPC_RST_IRQ;
         s_r.irq <= 1'b0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Zero wait states, always OKAY; hsize ignored, every access taken as a word
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_r.rdata;
   assign irq = s_r.irq;
endmodule
`default_nettype wire

//--- core/epc_divider.sv
// Prescaler: one tick pulse every DIV enabled cycles
`timescale 1ns/10ps
`default_nettype none
module epc_divider #(
   parameter int DIV = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic en,
   output logic tick
);
   import epc_pkg::*;
   typedef struct packed {
      logic [5:0] cnt;
      logic tick;
   } epc_div_state_t;
   epc_div_state_t s_r;
   epc_div_state_t s_nxt;
   localparam logic [5:0] LAST = 6'(DIV - 1);

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (en)
      begin
         if (s_r.cnt == LAST)
         begin
            s_nxt.cnt = 6'h00;
            s_nxt.tick = 1'b1;
         end
         else
         begin
            s_nxt.cnt = s_r.cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;
endmodule
`default_nettype wire

//--- core/epc_edge.sv
// Edge detector with selectable polarity, one-cycle pulse out
`timescale 1ns/10ps
`default_nettype none
module epc_edge (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic din,
   input wire logic rise_sel,
   output logic pulse
);
   import epc_pkg::*;
   typedef struct packed {
      logic prev;
      logic pulse;
   } epc_edge_state_t;
   epc_edge_state_t s_r;
   epc_edge_state_t s_nxt;

   always_comb
   begin
      s_nxt.prev = din;
      if (rise_sel)
      begin
         s_nxt.pulse = din & ~s_r.prev;
      end
      else
      begin
         s_nxt.pulse = ~din & s_r.prev;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign pulse = s_r.pulse;
endmodule
`default_nettype wire

//--- core/epc_pkg.sv
// Package: register map, field positions, reset values and clock codes
package epc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] EPC_IDX_CLK_CTRL = 16'hffb6;
   localparam logic [15:0] EPC_IDX_CTRL_STAT = 16'hffb7;
   localparam logic [15:0] EPC_IDX_COUNT = 16'hffb8;
   localparam logic [15:0] EPC_IDX_COMPARE = 16'hffb9;
   localparam logic [15:0] EPC_IDX_PORT_MODE = 16'hffc8;
   localparam logic [15:0] EPC_IDX_EDGE_SEL = 16'hfff2;
   localparam logic [15:0] EPC_IDX_IRQ_MASK = 16'hfff4;
   localparam logic [15:0] EPC_IDX_IRQ_STAT = 16'hfff7;
   localparam logic [31:0] EPC_ADDR_CLK_CTRL = {14'h0000, EPC_IDX_CLK_CTRL, 2'h0};
   localparam logic [31:0] EPC_ADDR_CTRL_STAT = {14'h0000, EPC_IDX_CTRL_STAT, 2'h0};
   localparam logic [31:0] EPC_ADDR_COUNT = {14'h0000, EPC_IDX_COUNT, 2'h0};
   localparam logic [31:0] EPC_ADDR_COMPARE = {14'h0000, EPC_IDX_COMPARE, 2'h0};
   localparam logic [31:0] EPC_ADDR_PORT_MODE = {14'h0000, EPC_IDX_PORT_MODE, 2'h0};
   localparam logic [31:0] EPC_ADDR_EDGE_SEL = {14'h0000, EPC_IDX_EDGE_SEL, 2'h0};
   localparam logic [31:0] EPC_ADDR_IRQ_MASK = {14'h0000, EPC_IDX_IRQ_MASK, 2'h0};
   localparam logic [31:0] EPC_ADDR_IRQ_STAT = {14'h0000, EPC_IDX_IRQ_STAT, 2'h0};
   // Field positions
   localparam int EPC_UPPER_SEL_LSB = 4;
   localparam int EPC_LOWER_SEL_LSB = 0;
   localparam int EPC_OVF_BIT = 7;
   localparam int EPC_CMF_BIT = 6;
   localparam int EPC_OVIE_BIT = 5;
   localparam int EPC_CCLR_BIT = 4;
   localparam int EPC_PIN_FN_BIT = 7;
   localparam int EPC_EDGE_BIT = 3;
   localparam int EPC_IRQ_OVF_BIT = 0;
   localparam int EPC_IRQ_CMF_BIT = 1;
   // Clock select codes; 000..010 pick external / 16-bit mode
   localparam logic [2:0] EPC_SEL_EXT_MAX = 3'h2;
   localparam logic [2:0] EPC_SEL_NONE = 3'h3;
   localparam logic [2:0] EPC_SEL_SYS32 = 3'h4;
   localparam logic [2:0] EPC_SEL_SYS6 = 3'h5;
   localparam logic [2:0] EPC_SEL_SYS4 = 3'h6;
   localparam logic [2:0] EPC_SEL_SUB4 = 3'h7;
   // Prescaler ratios
   localparam int EPC_DIV_SYS4 = 4;
   localparam int EPC_DIV_SYS6 = 6;
   localparam int EPC_DIV_SYS32 = 32;
   localparam int EPC_DIV_SUB4 = 4;
   // Reset values
   localparam logic [2:0] EPC_RST_SEL = 3'h0;
   localparam logic [15:0] EPC_RST_COUNT = 16'h0000;
   localparam logic [15:0] EPC_RST_COMPARE = 16'hffff;
   localparam logic EPC_RST_EDGE_RISE = 1'b0;
   localparam logic EPC_RST_PIN_FN = 1'b0;
   localparam logic [1:0] EPC_RST_IRQ = 2'h0;
   localparam logic [15:0] EPC_COUNT_MAX = 16'hffff;
   localparam logic [7:0] EPC_BYTE_MAX = 8'hff;
endpackage

//--- verif/epc_counter_props.sv
// Checker for bus answers, register readback and interrupt gating
`timescale 1ns/10ps
`default_nettype none
module epc_counter_props
   import epc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic event_input_pin,
   input wire logic subclk_in,
   input wire logic irq
);
   logic tk;
   logic rd_r;
   logic wr_r;
   logic [31:0] ad_r;
   logic [7:0] sh_r;
   logic [7:0] ex_r;
   logic [1:0] mk_r;
   assign tk = hsel && hready && htrans[1];
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of clock control and mask; clock control copy staged at the address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         ad_r <= 32'h0;
         sh_r <= 8'h00;
         ex_r <= 8'h00;
         mk_r <= 2'h0;
      end
      else
      begin
         rd_r <= tk && !hwrite;
         wr_r <= tk && hwrite;
         if (tk)
            ad_r <= haddr;
         if (tk)
            ex_r <= sh_r;
         if (wr_r && ad_r == EPC_ADDR_CLK_CTRL)
            sh_r <= hwdata[7:0] & 8'h77;
         if (wr_r && ad_r == EPC_ADDR_IRQ_MASK)
            mk_r <= hwdata[1:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_rd(logic [31:0] a);
      rd_r && ad_r == a;
   endsequence
   a_ready_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_irq_reset: assert property ($rose(hresetn) |-> !irq)
      else $error("irq high after reset");
   a_rdata_holds: assert property (!tk |=> $stable(hrdata))
      else $error("read data changed without a transfer");
   a_unmapped_zero: assert property (rd_r && ad_r[31:18] != 14'h0 |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_clk_readback: assert property (s_rd(EPC_ADDR_CLK_CTRL) |-> (hrdata & 32'hffffff77) == {24'h0, ex_r})
      else $error("clock control readback wrong");
   a_stat_zero: assert property (s_rd(EPC_ADDR_CTRL_STAT) |-> (hrdata & 32'hffffff0f) == 32'h0)
      else $error("status unused bits not zero");
   a_count_width: assert property (s_rd(EPC_ADDR_COUNT) |-> hrdata[31:16] == 16'h0)
      else $error("count wider than 16 bits");
   a_irq_gated: assert property (irq |-> (mk_r != 2'h0 || $past(mk_r) != 2'h0))
      else $error("irq high with gate closed");
endmodule
bind epc_counter epc_counter_props epc_counter_props_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .event_input_pin(event_input_pin), .subclk_in(subclk_in), .irq(irq));
`default_nettype wire

//--- verif/epc_pulse_src.sv
// Pulse source model for the event input pin
`timescale 1ns/10ps
`default_nettype none
module epc_pulse_src (
   input wire logic clk,
   input wire logic go,
   input wire logic [15:0] n,
   input wire logic [7:0] hi,
   output logic pin,
   output logic busy
);
   initial
   begin
      pin = 1'b0;
      busy = 1'b0;
   end
   // Pin idles low; each pulse high for hi cycles, low for two
   always @(posedge clk)
   begin
      if (go && !busy)
      begin
         busy <= 1'b1;
         for (int i = 0; i < n; i++)
         begin
            pin <= 1'b1;
            repeat (hi) @(posedge clk);
            pin <= 1'b0;
            repeat (2) @(posedge clk);
         end
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- verif/test_event_pulse_counter.sv
// Testbench for the event pulse counter
`timescale 1ns/10ps
`default_nettype none
module test_event_pulse_counter;
   import epc_pkg::*;
   localparam logic [31:0] CC = EPC_ADDR_CLK_CTRL;
   localparam logic [31:0] CS = EPC_ADDR_CTRL_STAT;
   localparam logic [31:0] CN = EPC_ADDR_COUNT;
   localparam logic [31:0] CP = EPC_ADDR_COMPARE;
   localparam logic [31:0] PM = EPC_ADDR_PORT_MODE;
   localparam logic [31:0] ES = EPC_ADDR_EDGE_SEL;
   localparam logic [31:0] IM = EPC_ADDR_IRQ_MASK;
   localparam logic [31:0] IS = EPC_ADDR_IRQ_STAT;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, irq, pin, busy, go = 1'b0;
   logic subclk_in = 1'b0;
   logic [31:0] hrdata;
   logic [15:0] n = 16'h0;
   logic [7:0] hi = 8'h1;
   int mismatches = 0;
   int n_checks = 0;
   always #20 hclk = ~hclk;
   always @(posedge hclk) subclk_in <= !subclk_in;
   epc_counter epc_counter_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .event_input_pin(pin),
      .subclk_in(subclk_in), .irq(irq));
   epc_pulse_src epc_pulse_src_inst (.clk(hclk), .go(go), .n(n), .hi(hi), .pin(pin),
      .busy(busy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test(input bit to);
      if (to)
         mismatches++;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic chk_rng(input string s, input logic [31:0] lo, input logic [31:0] up,
      input logic [31:0] g);
      n_checks++;
      if ((g >= lo && g <= up) !== 1'b1)
      begin
         mismatches++;
         $display("[ERR] %s exp %0d..%0d got %h", s, lo, up, g);
      end
   endtask
   task automatic wrdy;
      int k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         if (++k > 50)
            stop_test(1'b1);
         @(posedge hclk);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      wrdy;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wrdy;
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic ck_irq(input logic e);
      repeat (2) @(negedge hclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
      @(posedge hclk);
   endtask
   task automatic start_p(input logic [15:0] c, input logic [7:0] h);
      n <= c;
      hi <= h;
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
   endtask
   task automatic wait_p;
      int k;
      k = 0;
      @(posedge hclk);
      while (busy !== 1'b0)
      begin
         if (++k > 20000)
            stop_test(1'b1);
         @(posedge hclk);
      end
      repeat (4) @(posedge hclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdc(CC, 32'h0);
      rdc(CS, 32'h0);
      rdc(CN, 32'h0);
      ck_irq(1'b0);
   endtask
   task automatic t_regs;
      wr(CC, 32'h77);
      rdc(CC, 32'h77);
      wr(CC, 32'h0);
      wr(CS, 32'hf0);
      rdc(CS, 32'h30);
      wr(CN, 32'h1234);
      rdc(CN, 32'h1234);
      rdc(32'h40000, 32'h0);
      wr(CS, 32'h0);
   endtask
   // Mid-pulse read tells rising from falling edge
   task automatic t_edge;
      wr(PM, 32'h80);
      for (int m = 0; m < 6; m++)
      begin
         wr(CN, 32'h0);
         wr(CC, 32'(m % 3));
         wr(ES, m < 3 ? 32'h8 : 32'h0);
         start_p(16'h1, 8'h14);
         repeat (4) @(posedge hclk);
         rdc(CN, m < 3 ? 32'h1 : 32'h0);
         wait_p;
         rdc(CN, 32'h1);
      end
   endtask
   task automatic t_1024;
      wr(CN, 32'hfc00);
      wr(CC, 32'h0);
      wr(ES, 32'h8);
      wr(CS, 32'h20);
      wr(IM, 32'h1);
      start_p(16'h0400, 8'h1);
      wait_p;
      ck_irq(1'b1);
      rdc(CN, 32'h0);
      rdc(CS, 32'he0);
      rdc(IS, 32'h3);
      wr(PM, 32'h0);
      start_p(16'h3, 8'h1);
      wait_p;
      rdc(CN, 32'h0);
      wr(IM, 32'h0);
      ck_irq(1'b0);
      wr(CS, 32'h20);
      rdc(CS, 32'h20);
      wr(IS, 32'h3);
      rdc(IS, 32'h0);
   endtask
   task automatic t_cmp;
      wr(PM, 32'h80);
      for (int c = 0; c < 2; c++)
      begin
         wr(CN, 32'h0);
         wr(CP, 32'h2);
         wr(CS, c ? 32'h0 : 32'h10);
         start_p(16'h3, 8'h1);
         wait_p;
         rdc(CN, c ? 32'h3 : 32'h1);
         rdc(CS, c ? 32'h40 : 32'h50);
      end
   endtask
   // Upper field 011 leaves 16-bit mode: low byte wraps alone
   task automatic t_8bit;
      wr(PM, 32'h80);
      wr(ES, 32'h8);
      wr(CS, 32'h0);
      wr(CN, 32'h12ff);
      wr(CC, 32'h30);
      start_p(16'h1, 8'h1);
      wait_p;
      rdc(CN, 32'h1200);
      rdc(CS, 32'h0);
   endtask
   // Internal sources: 96 cycles give 96/div ticks, one of slack
   task automatic t_int;
      int dv[4] = '{32, 6, 4, 8};
      logic [31:0] q;
      wr(PM, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         wr(CN, 32'h0);
         wr(CC, 32'(i + 4));
         repeat (96) @(posedge hclk);
         wr(CC, 32'h3);
         ahb(1'b0, CN, 32'h0, q);
         chk_rng("ticks", 32'(96 / dv[i] - 1), 32'(96 / dv[i] + 1), q);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_regs;
      t_edge;
      t_1024;
      t_cmp;
      t_8bit;
      t_int;
      stop_test(1'b0);
   end
endmodule
`default_nettype wire
